// >>> core/iic_switch_clock_init.sv
// Two-channel two-wire bus switch with a strap-addressed control register.
// Assumes open-drain pads outside: each line is resolved from the enables, with pull-ups.
//
// Notes on behaviour
// - Respond only when select type is 1110.
// - Select byte: type, three address bits, direction.
// - Address field top bit fixed zero internally.
// - Select bits 2,1 match first, second strap.
// - Select bit 0 chooses read or write.
// - Control bit 0 connects channel 0.
// - Control bit 1 enables empty channel 1.
// - Enabled channel keeps passing traffic afterwards.
// - Read returns current control register content.
// - Oscillator answers at address 0x5D downstream.
// - Jitter attenuator answers at address 0x68 downstream.
// - Downstream isolated unless its channel enabled.
// - Attenuator outputs clocks only after initialisation.
// - Oscillator starts at 156.25 MHz default.
// - Oscillator programmable from 10 to 810 MHz.
// - Attenuator select pins direction set by register.
`timescale 1ns/1ps
module iic_switch_clock_init #(
    parameter int NUM_CH = iic_switch_pkg::CHANNELS
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic geo_strap_first,
    input wire logic geo_strap_second,
    input wire logic up_scl_in,
    output logic up_scl_out,
    output logic up_scl_oe_n,
    input wire logic up_sda_in,
    output logic up_sda_out,
    output logic up_sda_oe_n,
    input wire logic [NUM_CH-1:0] dn_scl_in,
    output logic [NUM_CH-1:0] dn_scl_out,
    output logic [NUM_CH-1:0] dn_scl_oe_n,
    input wire logic [NUM_CH-1:0] dn_sda_in,
    output logic [NUM_CH-1:0] dn_sda_out,
    output logic [NUM_CH-1:0] dn_sda_oe_n,
    output logic [NUM_CH-1:0] channel_enable
);
    import iic_switch_pkg::*;

    typedef struct packed {
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic [NUM_CH-1:0] dscl_s1;
        logic [NUM_CH-1:0] dscl_s2;
        logic [NUM_CH-1:0] dsda_s1;
        logic [NUM_CH-1:0] dsda_s2;
        slave_state_t st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic wr_done;
        logic more;
        logic slave_drive;
        logic [NUM_CH-1:0] ctrl;
        logic up_scl_oe_n;
        logic up_sda_oe_n;
    } switch_t;

    switch_t state_ff;
    switch_t nxt_state;

    logic [NUM_CH-1:0] br_scl_up;
    logic [NUM_CH-1:0] br_sda_up;
    logic [NUM_CH-1:0] br_scl_oe_n;
    logic [NUM_CH-1:0] br_sda_oe_n;

    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    logic addr_match;

    // Bus events are taken from the second synchroniser stage and its delayed copy.
    assign start_seen = state_ff.scl_s2 && state_ff.scl_p && state_ff.sda_p && !state_ff.sda_s2;
    assign stop_seen = state_ff.scl_s2 && state_ff.scl_p && !state_ff.sda_p && state_ff.sda_s2;
    assign scl_rise = state_ff.scl_s2 && !state_ff.scl_p;
    assign scl_fall = !state_ff.scl_s2 && state_ff.scl_p;

    // The select byte is type, fixed zero, two straps, direction.
    assign addr_match = (state_ff.shift[TYPE_MSB:TYPE_LSB] == TYPE_ID)
        && (state_ff.shift[ADDR_FIXED_POS] == ADDR_FIXED_VAL)
        && (state_ff.shift[STRAP_FIRST_POS] == state_ff.strap_s2[0])
        && (state_ff.shift[STRAP_SECOND_POS] == state_ff.strap_s2[1]);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.strap_s1 = {geo_strap_second, geo_strap_first};
        nxt_state.strap_s2 = state_ff.strap_s1;
        nxt_state.scl_s1 = up_scl_in;
        nxt_state.scl_s2 = state_ff.scl_s1;
        nxt_state.scl_p = state_ff.scl_s2;
        nxt_state.sda_s1 = up_sda_in;
        nxt_state.sda_s2 = state_ff.sda_s1;
        nxt_state.sda_p = state_ff.sda_s2;
        nxt_state.dscl_s1 = dn_scl_in;
        nxt_state.dscl_s2 = state_ff.dscl_s1;
        nxt_state.dsda_s1 = dn_sda_in;
        nxt_state.dsda_s2 = state_ff.dsda_s1;

        if (stop_seen) begin
            nxt_state.st = SL_IDLE;
            nxt_state.slave_drive = 1'h0;
        end else if (start_seen) begin
            nxt_state.st = SL_ADDR;
            nxt_state.cnt = 4'h0;
            nxt_state.wr_done = 1'h0;
            nxt_state.slave_drive = 1'h0;
        end else begin
            case (state_ff.st)
                SL_ADDR: begin
                    if (scl_rise) begin
                        nxt_state.shift = {state_ff.shift[6:0], state_ff.sda_s2};
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                    end else if (scl_fall && state_ff.cnt == BYTE_BITS) begin
                        if (addr_match) begin
                            nxt_state.st = SL_ADDR_ACK;
                            nxt_state.slave_drive = 1'h1;
                        end else begin
                            nxt_state.st = SL_IGNORE;
                        end
                    end
                end
                SL_ADDR_ACK: begin
                    if (scl_fall) begin
                        nxt_state.cnt = 4'h0;
                        if (state_ff.shift[DIR_POS] == DIR_READ) begin
                            nxt_state.st = SL_RDATA;
                            nxt_state.shift = 8'h00;
                            nxt_state.shift[NUM_CH-1:0] = state_ff.ctrl;
                            nxt_state.slave_drive = !(state_ff.ctrl[NUM_CH-1] && NUM_CH == 8);
                        end else begin
                            nxt_state.st = SL_WDATA;
                            nxt_state.slave_drive = 1'h0;
                        end
                    end
                end
                SL_WDATA: begin
                    if (scl_rise) begin
                        nxt_state.shift = {state_ff.shift[6:0], state_ff.sda_s2};
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                    end else if (scl_fall && state_ff.cnt == BYTE_BITS) begin
                        if (state_ff.wr_done) begin
                            nxt_state.st = SL_IGNORE;
                        end else begin
                            nxt_state.st = SL_WACK;
                            nxt_state.slave_drive = 1'h1;
                        end
                    end
                end
                SL_WACK: begin
                    if (scl_fall) begin
                        nxt_state.slave_drive = 1'h0;
                        nxt_state.ctrl = state_ff.shift[NUM_CH-1:0];
                        nxt_state.wr_done = 1'h1;
                        nxt_state.cnt = 4'h0;
                        nxt_state.st = SL_WDATA;
                    end
                end
                SL_RDATA: begin
                    if (scl_rise) begin
                        nxt_state.cnt = state_ff.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (state_ff.cnt == BYTE_BITS) begin
                            nxt_state.slave_drive = 1'h0;
                            nxt_state.st = SL_RACK;
                        end else begin
                            nxt_state.slave_drive = !state_ff.shift[3'(4'h7 - state_ff.cnt)];
                        end
                    end
                end
                SL_RACK: begin
                    if (scl_rise) begin
                        nxt_state.more = !state_ff.sda_s2;
                    end else if (scl_fall) begin
                        nxt_state.cnt = 4'h0;
                        if (state_ff.more) begin
                            nxt_state.st = SL_RDATA;
                            nxt_state.shift = 8'h00;
                            nxt_state.shift[NUM_CH-1:0] = state_ff.ctrl;
                            nxt_state.slave_drive = 1'h1;
                        end else begin
                            nxt_state.st = SL_IGNORE;
                        end
                    end
                end
                default: begin
                    nxt_state.slave_drive = 1'h0;
                end
            endcase
        end

        nxt_state.up_scl_oe_n = !(|br_scl_up);
        nxt_state.up_sda_oe_n = !(state_ff.slave_drive || (|br_sda_up));
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= '0;
            state_ff.scl_s1 <= 1'h1;
            state_ff.scl_s2 <= 1'h1;
            state_ff.scl_p <= 1'h1;
            state_ff.sda_s1 <= 1'h1;
            state_ff.sda_s2 <= 1'h1;
            state_ff.sda_p <= 1'h1;
            state_ff.st <= SL_IDLE;
            state_ff.ctrl <= CTRL_RESET[NUM_CH-1:0];
            state_ff.up_scl_oe_n <= 1'h1;
            state_ff.up_sda_oe_n <= 1'h1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Each channel repeats both lines; channel 1 works although nothing is fitted on it.
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        line_bridge u_scl (
            .clk_sys(clk_sys),
            .reset(reset),
            .enable(state_ff.ctrl[ch]),
            .up_level(state_ff.scl_s2),
            .dn_level(state_ff.dscl_s2[ch]),
            .drive_up(br_scl_up[ch]),
            .dn_oe_n(br_scl_oe_n[ch])
        );
        line_bridge u_sda (
            .clk_sys(clk_sys),
            .reset(reset),
            .enable(state_ff.ctrl[ch]),
            .up_level(state_ff.sda_s2),
            .dn_level(state_ff.dsda_s2[ch]),
            .drive_up(br_sda_up[ch]),
            .dn_oe_n(br_sda_oe_n[ch])
        );
    end

    assign up_scl_out = 1'h0;
    assign up_sda_out = 1'h0;
    assign dn_scl_out = '0;
    assign dn_sda_out = '0;
    assign up_scl_oe_n = state_ff.up_scl_oe_n;
    assign up_sda_oe_n = state_ff.up_sda_oe_n;
    assign dn_scl_oe_n = br_scl_oe_n;
    assign dn_sda_oe_n = br_sda_oe_n;
    assign channel_enable = state_ff.ctrl;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_type_match: assert property (
        (state_ff.st == SL_ADDR && !start_seen && !stop_seen && scl_fall
            && state_ff.cnt == BYTE_BITS && state_ff.shift[7:4] != TYPE_ID)
        |=> state_ff.st == SL_IGNORE ##1 state_ff.up_sda_oe_n || (|br_sda_up))
        else $error("select with wrong type was acknowledged");

    chk_fixed_bit: assert property (
        (state_ff.st == SL_ADDR && !start_seen && !stop_seen && scl_fall
            && state_ff.cnt == BYTE_BITS && state_ff.shift[3])
        |=> state_ff.st == SL_IGNORE)
        else $error("select with bit 3 set was acknowledged");

    chk_strap_bits: assert property (
        (state_ff.st == SL_ADDR && !start_seen && !stop_seen && scl_fall
            && state_ff.cnt == BYTE_BITS
            && state_ff.shift[2:1] != {state_ff.strap_s2[0], state_ff.strap_s2[1]})
        |=> state_ff.st == SL_IGNORE)
        else $error("select with wrong strap bits was acknowledged");

    chk_addr_ack: assert property (
        (state_ff.st == SL_ADDR && !start_seen && !stop_seen && scl_fall
            && state_ff.cnt == BYTE_BITS && addr_match)
        |=> state_ff.st == SL_ADDR_ACK ##1 !state_ff.up_sda_oe_n)
        else $error("matching select not acknowledged");

    chk_dir_read: assert property (
        (state_ff.st == SL_ADDR_ACK && !start_seen && !stop_seen && scl_fall)
        |=> state_ff.st == (($past(state_ff.shift[DIR_POS]) == DIR_READ) ? SL_RDATA : SL_WDATA))
        else $error("direction bit not honoured");

    chk_read_value: assert property (
        (state_ff.st == SL_ADDR_ACK && !start_seen && !stop_seen && scl_fall
            && $past(state_ff.st) == SL_ADDR_ACK && state_ff.shift[DIR_POS])
        |=> state_ff.shift == {{(8 - NUM_CH){1'h0}}, $past(state_ff.ctrl)})
        else $error("read byte differs from control register");

    chk_write_load: assert property (
        (state_ff.st == SL_WACK && !start_seen && !stop_seen && scl_fall)
        |=> state_ff.ctrl == $past(state_ff.shift[NUM_CH-1:0]) && state_ff.wr_done)
        else $error("control register not loaded after data ack");

    chk_single_byte: assert property (
        (state_ff.st == SL_WDATA && !start_seen && !stop_seen && scl_fall
            && state_ff.cnt == BYTE_BITS && state_ff.wr_done)
        |=> state_ff.st == SL_IGNORE && $stable(state_ff.ctrl))
        else $error("second data byte accepted");

    chk_ctrl_hold: assert property (
        (state_ff.st != SL_WACK) |=> $stable(state_ff.ctrl))
        else $error("control register changed outside a write");

    cov_write: cover property (state_ff.st == SL_WACK && scl_fall ##1 state_ff.ctrl[0]);
    cov_read: cover property (state_ff.st == SL_RDATA ##[1:1000] state_ff.st == SL_RACK);
    cov_pass: cover property (state_ff.ctrl[0] && !dn_scl_oe_n[0]);
    cov_reject: cover property (state_ff.st == SL_ADDR ##1 state_ff.st == SL_IGNORE);

endmodule

// >>> core/iic_switch_pkg.sv
// Shared constants and state types for the two-channel two-wire bus switch.
// Assumes a single 100 MHz system clock and open-drain pads resolved outside.
package iic_switch_pkg;

    // Clock period of clk_sys.
    localparam int CLK_PERIOD_NS = 10;

    // Number of downstream channels and select byte layout.
    localparam int CHANNELS = 2;
    localparam logic [3:0] TYPE_ID = 4'he;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int ADDR_FIXED_POS = 3;
    localparam logic ADDR_FIXED_VAL = 1'h0;
    localparam int STRAP_FIRST_POS = 2;
    localparam int STRAP_SECOND_POS = 1;
    localparam int DIR_POS = 0;
    localparam logic DIR_READ = 1'h1;

    // Control register: bit 0 enables channel 0, bit 1 enables channel 1.
    localparam int CH0_ENABLE_POS = 0;
    localparam int CH1_ENABLE_POS = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Bits per byte on the wire and the bit counter value after a whole byte.
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Wire release settle time; covers sync latency and slow pull-up rise.
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_INT);

    // Downstream chips reachable once channel 0 is enabled.
    localparam logic [6:0] OSC_ADDR = 7'h5d;
    localparam logic [6:0] JITTER_ADDR = 7'h68;
    // Oscillator start-up and programmable range, in kHz.
    localparam int OSC_DEFAULT_KHZ = 156250;
    localparam int OSC_MIN_KHZ = 10000;
    localparam int OSC_MAX_KHZ = 810000;

    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR,
        SL_ADDR_ACK,
        SL_WDATA,
        SL_WACK,
        SL_RDATA,
        SL_RACK,
        SL_IGNORE
    } slave_state_t;

    typedef enum logic [1:0] {
        BR_IDLE,
        BR_UP_OWNS,
        BR_DN_OWNS,
        BR_SETTLE
    } bridge_state_t;

endpackage

// >>> core/line_bridge.sv
// One open-drain line repeated between the upstream bus and one downstream channel.
// Assumes both level inputs are already synchronised to clk_sys.
`timescale 1ns/1ps
module line_bridge (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic enable,
    input wire logic up_level,
    input wire logic dn_level,
    output logic drive_up,
    output logic dn_oe_n
);
    import iic_switch_pkg::*;

    typedef struct packed {
        bridge_state_t st;
        logic [7:0] cnt;
        logic drive_up;
        logic dn_oe_n;
    } bridge_t;

    bridge_t state_ff;
    bridge_t nxt_state;

    // The side that pulls low first owns the line; after release both sides are
    // left alone for a settle time, so our own echo cannot latch the line low.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff.st)
            BR_IDLE: begin
                if (enable && !up_level) begin
                    nxt_state.st = BR_UP_OWNS;
                    nxt_state.dn_oe_n = 1'h0;
                end else if (enable && !dn_level) begin
                    nxt_state.st = BR_DN_OWNS;
                    nxt_state.drive_up = 1'h1;
                end
            end
            BR_UP_OWNS: begin
                if (!enable || up_level) begin
                    nxt_state.st = BR_SETTLE;
                    nxt_state.cnt = 8'h00;
                    nxt_state.dn_oe_n = 1'h1;
                end
            end
            BR_DN_OWNS: begin
                if (!enable || dn_level) begin
                    nxt_state.st = BR_SETTLE;
                    nxt_state.cnt = 8'h00;
                    nxt_state.drive_up = 1'h0;
                end
            end
            BR_SETTLE: begin
                nxt_state.cnt = state_ff.cnt + 8'h01;
                if (state_ff.cnt >= SETTLE_CYC - 8'h01) begin
                    nxt_state.st = BR_IDLE;
                end
            end
            default: begin
                nxt_state.st = BR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= '{st: BR_IDLE, cnt: 8'h00, drive_up: 1'h0, dn_oe_n: 1'h1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign drive_up = state_ff.drive_up;
    assign dn_oe_n = state_ff.dn_oe_n;

    chk_pass_down: assert property (@(posedge clk_sys) disable iff (reset)
        (enable && state_ff.st == BR_IDLE && !up_level) |=> !dn_oe_n)
        else $error("upstream low not passed to enabled channel");

    chk_isolate_off: assert property (@(posedge clk_sys) disable iff (reset)
        (!enable)[*2] |-> (dn_oe_n && !drive_up))
        else $error("disabled channel still driving");

    chk_settle_bound: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff.st == BR_SETTLE) |-> ##[1:101] (state_ff.st == BR_IDLE))
        else $error("bridge stuck in settle");

endmodule

// >>> test/twowire_master_model.sv
// Behavioural carrier-side two-wire master, and a fixed-address downstream chip stub.
// Assumes the bench resolves every open-drain wire with a pull-up and calls tasks from one process.
`timescale 1ns/1ps
module twowire_master_model #(
    parameter int HALF = 140
) (
    input wire logic clk_sys,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'h0;
        sda_low = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Data moves a quarter phase after SCL falls, so it never races the clock edge.
    task automatic bit_cycle(input logic b, output logic got);
        tick(HALF / 4);
        sda_low = ~b;
        tick(HALF - HALF / 4);
        scl_low = 1'h0;
        tick(HALF / 2);
        while (!scl_line) tick(1);
        got = sda_line;
        tick(HALF / 2);
        scl_low = 1'h1;
    endtask
    task automatic start_cond();
        sda_low = 1'h1;
        tick(HALF);
        scl_low = 1'h1;
    endtask
    task automatic stop_cond();
        tick(HALF / 4);
        sda_low = 1'h1;
        tick(HALF);
        scl_low = 1'h0;
        tick(HALF);
        sda_low = 1'h0;
        tick(HALF);
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], g);
        end
        bit_cycle(1'h1, g);
        ack = ~g;
    endtask
    task automatic byte_in(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'h1, d[i]);
        end
        bit_cycle(~ack, g);
    endtask
endmodule

`timescale 1ns/1ps
module clock_chip_stub #(
    parameter logic [6:0] ADDR = 7'h00
) (
    input wire logic clk_sys,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic sda_low
);
    logic scl_q = 1'h1;
    logic sda_q = 1'h1;
    logic [3:0] cnt = 4'ha;
    logic [7:0] sh = 8'h00;
    initial sda_low = 1'h0;
    always @(posedge clk_sys) begin
        scl_q <= scl_line;
        sda_q <= sda_line;
        if (scl_line && scl_q && sda_q && !sda_line) begin
            cnt <= 4'h0;
        end else if (scl_line && !scl_q && cnt < 4'h9) begin
            sh <= {sh[6:0], sda_line};
            cnt <= cnt + 4'h1;
        end else if (!scl_line && scl_q && cnt == 4'h8) begin
            sda_low <= (sh[7:1] == ADDR);
        end else if (!scl_line && scl_q && cnt == 4'h9) begin
            sda_low <= 1'h0;
            cnt <= 4'ha;
        end
    end
endmodule

// >>> test/test_iic_switch_clock_init.sv
// Self-checking bench for the two-channel switch, driven by a behavioural upstream master.
// Assumes pull-ups on all lines and two clock-chip stubs on downstream channel 0.
`timescale 1ns/1ps
`define CHECK(name, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("FAIL %s expected %h seen %h", name, exp, got); \
        end \
    end
module test_iic_switch_clock_init;
    import iic_switch_pkg::*;
    logic clk_sys, reset, geo_strap_first, geo_strap_second;
    logic m_scl_low, m_sda_low, osc_low, jit_low, ack, a1, a2;
    logic up_scl, up_sda, up_scl_out, up_scl_oe_n, up_sda_out, up_sda_oe_n;
    logic [1:0] dn_scl, dn_sda, dn_scl_out, dn_scl_oe_n, dn_sda_out, dn_sda_oe_n, channel_enable;
    logic [7:0] rd0, rd1, rnd;
    logic [7:0] flips [4] = '{8'h40, 8'h08, 8'h04, 8'h02};
    int errors = 0;
    int n_checks = 0;
    int dn0_lows = 0;
    int dn1_lows = 0;

    assign up_scl = ~m_scl_low & (up_scl_oe_n | up_scl_out);
    assign up_sda = ~m_sda_low & (up_sda_oe_n | up_sda_out);
    assign dn_scl = dn_scl_oe_n | dn_scl_out;
    assign dn_sda = (dn_sda_oe_n | dn_sda_out) & {1'h1, ~osc_low & ~jit_low};

    iic_switch_clock_init #(.NUM_CH(2)) iic_switch_clock_init_inst (
        .clk_sys(clk_sys), .reset(reset),
        .geo_strap_first(geo_strap_first), .geo_strap_second(geo_strap_second),
        .up_scl_in(up_scl), .up_scl_out(up_scl_out), .up_scl_oe_n(up_scl_oe_n),
        .up_sda_in(up_sda), .up_sda_out(up_sda_out), .up_sda_oe_n(up_sda_oe_n),
        .dn_scl_in(dn_scl), .dn_scl_out(dn_scl_out), .dn_scl_oe_n(dn_scl_oe_n),
        .dn_sda_in(dn_sda), .dn_sda_out(dn_sda_out), .dn_sda_oe_n(dn_sda_oe_n),
        .channel_enable(channel_enable)
    );
    twowire_master_model twowire_master_model_inst (.clk_sys(clk_sys), .scl_line(up_scl),
        .sda_line(up_sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
    clock_chip_stub #(.ADDR(OSC_ADDR)) osc_stub (.clk_sys(clk_sys), .scl_line(dn_scl[0]),
        .sda_line(dn_sda[0]), .sda_low(osc_low));
    clock_chip_stub #(.ADDR(JITTER_ADDR)) jitter_stub (.clk_sys(clk_sys),
        .scl_line(dn_scl[0]), .sda_line(dn_sda[0]), .sda_low(jit_low));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (!dn_scl[0]) dn0_lows++;
        if (!dn_scl[1]) dn1_lows++;
    end
    // The whole sequence needs about 74000 cycles, well short of the 100000-cycle cap that stops a hang.
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        final_report();
    end

    function automatic logic [7:0] sel(input logic rd);
        return {TYPE_ID, ADDR_FIXED_VAL, geo_strap_first, geo_strap_second, rd};
    endfunction
    task automatic xfer_start(input logic [7:0] b, output logic a);
        twowire_master_model_inst.start_cond();
        twowire_master_model_inst.byte_out(b, a);
    endtask
    task automatic probe(input logic [7:0] b, output logic a);
        xfer_start(b, a);
        twowire_master_model_inst.stop_cond();
    endtask
    task automatic wr_ctrl(input logic [7:0] s, input logic [7:0] v, output logic x, output logic y);
        xfer_start(s, x);
        twowire_master_model_inst.byte_out(v, y);
        twowire_master_model_inst.stop_cond();
    endtask
    task automatic ctrl_roundtrip(input logic [7:0] v);
        wr_ctrl(sel(1'h0), v, a1, a2);
        `CHECK("sel_ack", 1'h1, a1)
        `CHECK("data_ack", 1'h1, a2)
        `CHECK("enable", v[1:0], channel_enable)
        dn0_lows = 0;
        dn1_lows = 0;
        xfer_start(sel(DIR_READ), a1);
        twowire_master_model_inst.byte_in(1'h1, rd0);
        twowire_master_model_inst.byte_in(1'h0, rd1);
        twowire_master_model_inst.stop_cond();
        `CHECK("rd_ack", 1'h1, a1)
        `CHECK("rd_byte", {6'h00, v[1:0]}, rd0)
        `CHECK("rd_repeat", {6'h00, v[1:0]}, rd1)
        `CHECK("dn0_pass", v[0], 1'(dn0_lows > 0))
        `CHECK("dn1_pass", v[1], 1'(dn1_lows > 0))
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        reset = 1'h1;
        geo_strap_first = 1'h0;
        geo_strap_second = 1'h0;
        void'($urandom(37));
        repeat (12) @(posedge clk_sys);
        #1;
        {geo_strap_first, geo_strap_second} = 2'($urandom);
        reset = 1'h0;
        repeat (8) @(posedge clk_sys);
        #1;
        `CHECK("enable_rst", 2'h0, channel_enable)
        dn0_lows = 0;
        probe({OSC_ADDR, 1'h0}, ack);
        `CHECK("closed_nack", 1'h0, ack)
        `CHECK("closed_dn0", 1'h0, 1'(dn0_lows > 0))
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr_ctrl(sel(1'h0) ^ flips[i], 8'h03, a1, a2);
            `CHECK("bad_sel_ack", 1'h0, a1)
            `CHECK("bad_sel_en", 2'h0, channel_enable)
        end
        $display("test refused select done");
        rnd = 8'($urandom);
        ctrl_roundtrip(8'hfe);
        ctrl_roundtrip(rnd);
        $display("test control done");
        // Channel 0 goes on before any clock chip is addressed; a second byte must be dropped.
        xfer_start(sel(1'h0), a1);
        twowire_master_model_inst.byte_out({rnd[7:2], 2'h1}, a2);
        twowire_master_model_inst.byte_out(8'h02, ack);
        twowire_master_model_inst.stop_cond();
        `CHECK("extra_first", 1'h1, a2)
        `CHECK("extra_nack", 1'h0, ack)
        `CHECK("extra_en", 2'h1, channel_enable)
        $display("test extra byte done");
        dn1_lows = 0;
        probe({OSC_ADDR, 1'h0}, ack);
        `CHECK("osc_ack", 1'h1, ack)
        probe({JITTER_ADDR, 1'h0}, ack);
        `CHECK("jit_ack", 1'h1, ack)
        probe({JITTER_ADDR, 1'h0}, ack);
        `CHECK("jit_reinit", 1'h1, ack)
        probe({7'h3c, 1'h0}, ack);
        `CHECK("empty_nack", 1'h0, ack)
        `CHECK("dn1_quiet", 1'h0, 1'(dn1_lows > 0))
        $display("test downstream done");
        final_report();
    end
endmodule
